// *** hw/self_recovering_watchdog.sv ***
// How it works
// - Silent host: reset on after one, off after two
// - Reset keeps toggling each period until cleared
// - One interval serves as timeout and power-on
// - No power-on unless supply reaches activation
// - Power-on starts when sense and supply good
// - Sense below warning level asserts save_warning_n
// - Sense below reset level forces both resets
// - Low sense pulses of 10 us recognised
// - Clear pulse zeroes timer, releases reset
// - Clears ignored until power-on delay completes
// - Supply drop stops timer, forces all outputs
// - After sense reset, wait for fresh power-up
`timescale 1ns/1ns
`default_nettype none

module self_recovering_watchdog #(
  parameter int unsigned TIMEOUT_CYCLES = watchdog_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire watchdog_pkg::comparators_s comp_i,
  input  wire logic                       timer_clear_n_i,
  output logic                            reset_out_o,
  output logic                            reset_out_n_o,
  output logic                            save_warning_n_o
);
  import watchdog_pkg::*;

  localparam int unsigned DB_CYCLES =
    (TIMEOUT_CYCLES / DEBOUNCE_DIV) > 0 ? TIMEOUT_CYCLES / DEBOUNCE_DIV : 1;

  //////////////////////////////////////////////////////////////////////////
  // Comparator conditioning.

  logic supply_ok;
  logic startup_ok;
  logic warn_ok;
  logic reset_ok;

  // Start-up comparators are debounced over the long window.
  level_filter #(.HOLD_CYCLES(DB_CYCLES)) u_supply_filter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .level_i   (comp_i.supply_on),
    .level_o   (supply_ok)
  );

  level_filter #(.HOLD_CYCLES(DB_CYCLES)) u_startup_filter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .level_i   (comp_i.vin_startup),
    .level_o   (startup_ok)
  );

  // Falling comparators use a short window so a 10 us dip is still caught.
  level_filter #(.HOLD_CYCLES(VIN_LOW_CYCLES / 2)) u_warn_filter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .level_i   (comp_i.vin_warning),
    .level_o   (warn_ok)
  );

  level_filter #(.HOLD_CYCLES(VIN_LOW_CYCLES / 2)) u_reset_filter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .level_i   (comp_i.vin_reset),
    .level_o   (reset_ok)
  );

  //////////////////////////////////////////////////////////////////////////
  // Timer clear input: synchronised, then a qualified low pulse.

  logic                clr_sync_a;
  logic                clr_sync_b;
  logic [7:0]          clr_low_count;
  logic                clr_taken;
  logic                clear_pulse;

  // Two flip-flops before anything looks at the pin.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_sync_a <= 1'b1;
      clr_sync_b <= 1'b1;
    end else begin
      clr_sync_a <= timer_clear_n_i;
      clr_sync_b <= clr_sync_a;
    end
  end

  // One clear per low pulse, once it has stood long enough; a pin tied low
  // therefore gives only its first clear, and the reset outputs then free-run as a square wave.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_low_count <= '0;
      clr_taken     <= 1'b0;
    end else if (clr_sync_b) begin
      clr_low_count <= '0;
      clr_taken     <= 1'b0;
    end else if (clear_pulse) begin
      clr_taken     <= 1'b1;
    end else if (!clr_taken) begin
      clr_low_count <= clr_low_count + 1'b1;
    end
  end

  assign clear_pulse = !clr_sync_b && !clr_taken &&
                       (clr_low_count >= 8'(CLEAR_MIN_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////
  // Supervisor state machine and interval timer.

  wd_state_e          state;
  logic               reset_state;
  logic [COUNT_W-1:0] timer;
  logic               timer_done;
  logic               go_off;

  assign timer_done = (timer >= COUNT_W'(TIMEOUT_CYCLES - 1));
  // Losing the supply or falling under the reset level ends all activity.
  assign go_off = !supply_ok || !reset_ok;

  // Sequencing of power-on, watchdog run and self-recovery toggling.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_OFF;
    end else if (go_off) begin
      state <= ST_OFF;
    end else begin
      unique case (state)
        ST_OFF: begin
          if (supply_ok && startup_ok) begin
            state <= ST_POWER_ON;
          end
        end
        ST_POWER_ON: begin
          if (timer_done) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!clear_pulse && timer_done) begin
            state <= ST_TOGGLE;
          end
        end
        ST_TOGGLE: begin
          if (clear_pulse) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // The timer runs only while powered; a qualified clear zeroes it, but
  // never during the power-on delay.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer <= '0;
    end else if (go_off || state == ST_OFF) begin
      timer <= '0;
    end else if (clear_pulse && state != ST_POWER_ON) begin
      timer <= '0;
    end else if (timer_done) begin
      timer <= '0;
    end else begin
      timer <= timer + 1'b1;
    end
  end

  // One internal reset state; active in off and power-on, inverted at each
  // timeout in toggle, cleared by a qualified clear.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_state <= 1'b1;
    end else if (go_off) begin
      reset_state <= 1'b1;
    end else begin
      unique case (state)
        ST_OFF: reset_state <= 1'b1;
        ST_POWER_ON: begin
          if (timer_done) begin
            reset_state <= 1'b0;
          end
        end
        ST_RUN: begin
          if (clear_pulse) begin
            reset_state <= 1'b0;
          end else if (timer_done) begin
            reset_state <= 1'b1;
          end
        end
        ST_TOGGLE: begin
          if (clear_pulse) begin
            reset_state <= 1'b0;
          end else if (timer_done) begin
            reset_state <= !reset_state;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output registers.

  // Both reset pins come from the same next value in one process.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_out_o   <= 1'b1;
      reset_out_n_o <= 1'b0;
    end else begin
      reset_out_o   <= reset_state;
      reset_out_n_o <= !reset_state;
    end
  end

  // Warning goes active under the warning level or on supply loss, and is
  // only released once the sense input is back above the start-up level.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      save_warning_n_o <= 1'b0;
    end else if (!supply_ok || !warn_ok) begin
      save_warning_n_o <= 1'b0;
    end else if (startup_ok) begin
      save_warning_n_o <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** hw/watchdog_pkg.sv ***
package watchdog_pkg;

  // Clock rate of the system clock in kHz, used to turn times into counts.
  localparam int unsigned CLK_KHZ          = 100000;
  // Nominal timeout period and power-on reset time, in ms.
  localparam int unsigned TIMEOUT_MS       = 100;
  localparam int unsigned TIMEOUT_CYCLES   = TIMEOUT_MS * CLK_KHZ;
  // Debounce of the start-up comparators is one sixty-fourth of the timeout.
  localparam int unsigned DEBOUNCE_DIV     = 64;
  // Shortest low excursion on the sense input that must be acted upon, in us.
  localparam int unsigned VIN_LOW_MIN_US   = 10;
  localparam int unsigned VIN_LOW_CYCLES   = VIN_LOW_MIN_US * (CLK_KHZ / 1000);
  // Shortest timer clear pulse, in ns; anything under it may be ignored.
  localparam int unsigned CLEAR_MIN_NS     = 150;
  localparam int unsigned CLK_PERIOD_NS    = 1000000 / CLK_KHZ;
  localparam int unsigned CLEAR_MIN_CYCLES =
    (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the timer and filter cycle counters.
  localparam int unsigned COUNT_W          = 32;

  // Digitised comparator outputs, each high when the voltage is above.
  typedef struct packed {
    logic supply_on;   // Regulated supply at or above activation level.
    logic vin_startup; // Sense input above vin_startup_level.
    logic vin_warning; // Sense input above vin_warning_level.
    logic vin_reset;   // Sense input above vin_reset_level.
  } comparators_s;

  // Supervisor states; Gray codes along power-up, run and toggle.
  typedef enum logic [1:0] {
    ST_OFF      = 2'b00,
    ST_POWER_ON = 2'b01,
    ST_RUN      = 2'b11,
    ST_TOGGLE   = 2'b10
  } wd_state_e;

endpackage

// *** hw/level_filter.sv ***
`timescale 1ns/1ns
`default_nettype none

// Synchronises one comparator level and accepts a change only after it
// has been stable for HOLD_CYCLES clocks.
module level_filter #(
  parameter int unsigned HOLD_CYCLES = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output logic      level_o
);
  import watchdog_pkg::*;

  logic               sync_a;
  logic               sync_b;
  logic [COUNT_W-1:0] stable_count;

  // Two flip-flops bring the level into the clock domain.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= level_i;
      sync_b <= sync_a;
    end
  end

  // A change is taken only once it outlasts the hold time.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_count <= '0;
      level_o      <= 1'b0;
    end else if (sync_b == level_o) begin
      stable_count <= '0;
    end else if (stable_count >= COUNT_W'(HOLD_CYCLES - 1)) begin
      stable_count <= '0;
      level_o      <= sync_b;
    end else begin
      stable_count <= stable_count + 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** sim/wd_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// Relates the supervisor outputs to the settled history of its inputs.
module wd_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 640
) (
  input wire logic                       clk_sys_i,
  input wire logic                       rst_n_i,
  input wire watchdog_pkg::comparators_s comp_i,
  input wire logic                       timer_clear_n_i,
  input wire logic                       reset_out_o,
  input wire logic                       reset_out_n_o,
  input wire logic                       save_warning_n_o
);
  import watchdog_pkg::*;
  localparam int T = TIMEOUT_CYCLES;
  localparam int D = T / 64;
  // Settling time of the sense comparator filters, with a little margin.
  localparam int F = VIN_LOW_CYCLES / 2 + 8;
  int   good;
  int   slo;
  int   rlo;
  int   wlo;
  int   clo;
  int   qt;
  int   stb;
  logic last;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // History counters. The power count only starts once the start-up level
  // is seen, since a supervisor in its off state must not count as powered.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      good <= 0;
      slo <= 0;
      rlo <= 0;
      wlo <= 0;
      clo <= 0;
      qt <= 0;
      stb <= 0;
      last <= 1'h1;
    end else begin
      good <= (!comp_i.supply_on || !comp_i.vin_reset) ? 0 :
              (good == 0 && !comp_i.vin_startup) ? 0 : good + 1;
      slo <= comp_i.supply_on ? 0 : slo + 1;
      rlo <= comp_i.vin_reset ? 0 : rlo + 1;
      wlo <= comp_i.vin_warning ? 0 : wlo + 1;
      clo <= timer_clear_n_i ? 0 : clo + 1;
      qt <= (!timer_clear_n_i || good == 0) ? 0 : qt + 1;
      stb <= (reset_out_o != last) ? 0 : stb + 1;
      last <= reset_out_o;
    end
  end
  property p_compl; reset_out_n_o == !reset_out_o; endproperty
  a_compl: assert property (p_compl)
    else $error("reset pair not complementary");
  property p_pwr; good != 0 && good < T |-> reset_out_o; endproperty
  a_pwr: assert property (p_pwr)
    else $error("reset released too early");
  property p_rel; good == T + F + 20 |-> !reset_out_o; endproperty
  a_rel: assert property (p_rel)
    else $error("reset not released after power-on");
  property p_sup; slo > D + 8 |-> reset_out_o && !save_warning_n_o;
  endproperty
  a_sup: assert property (p_sup)
    else $error("supply drop not forcing outputs");
  property p_vrst; rlo > F |-> reset_out_o; endproperty
  a_vrst: assert property (p_vrst)
    else $error("sense drop not forcing reset");
  property p_warn; wlo > F |-> !save_warning_n_o; endproperty
  a_warn: assert property (p_warn)
    else $error("warning not raised");
  property p_clr; clo == 20 && good > T + F + 30 |-> ##[0:4] !reset_out_o;
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear did not release reset");
  property p_tog; qt > 2 * T + D + 40 |-> stb <= T + 2; endproperty
  a_tog: assert property (p_tog)
    else $error("reset stopped toggling");
  property p_first; $rose(reset_out_o) && good > T + D + 30 |-> qt > T - 30;
  endproperty
  a_first: assert property (p_first)
    else $error("reset raised before timeout");
endmodule

bind self_recovering_watchdog wd_chk #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (
  .clk_sys_i       (clk_sys_i),
  .rst_n_i         (rst_n_i),
  .comp_i          (comp_i),
  .timer_clear_n_i (timer_clear_n_i),
  .reset_out_o     (reset_out_o),
  .reset_out_n_o   (reset_out_n_o),
  .save_warning_n_o(save_warning_n_o)
);
`default_nettype wire

// *** sim/host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host side: each kick becomes one low clear pulse of len_i cycles.
module host_model (
  input  wire logic       clk_sys_i,
  input  wire logic       kick_i,
  input  wire logic [7:0] len_i,
  output wire logic       timer_clear_n_o
);
  logic [7:0] left = 8'h00;
  // Pulses under 15 cycles may be missed, so callers never ask for less.
  always @(posedge clk_sys_i) begin
    if (left != 8'h00)
      left <= left - 8'h01;
    else if (kick_i)
      left <= len_i;
  end
  assign timer_clear_n_o = (left == 8'h00);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import watchdog_pkg::*;
  localparam int T = 640;
  localparam int D = T / 64;
  // Sense comparators settle only after their filter window, both ways.
  localparam int F = VIN_LOW_CYCLES / 2 + 8;
  logic         clk = 1'h0;
  logic         rst_n = 1'h0;
  logic         kick = 1'h0;
  logic [7:0]   len = 8'h14;
  comparators_s comp = 4'hF;
  logic         clr_n;
  logic         ro;
  logic         ron;
  logic         sw;
  int           error_cnt = 0;
  int           compares = 0;
  int           cycles = 0;

  // Free-running system clock.
  always #5 clk = ~clk;
  host_model HOST (.clk_sys_i(clk), .kick_i(kick), .len_i(len),
                   .timer_clear_n_o(clr_n));
  self_recovering_watchdog #(.TIMEOUT_CYCLES(T)) DUT (
    .clk_sys_i(clk), .rst_n_i(rst_n), .comp_i(comp),
    .timer_clear_n_i(clr_n), .reset_out_o(ro), .reset_out_n_o(ron),
    .save_warning_n_o(sw));

  // Hang guard; the tests need about 9040 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic e, input logic a);
    compares++;
    if (a !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task kick_h(input logic [7:0] l);
    len = l;
    kick = 1'h1;
    cyc(1);
    kick = 1'h0;
    cyc(1);
  endtask
  task t_pwr;
    cyc(T / 2);
    chk(1'h1, ro);
    chk(1'h0, ron);
    // Wait out the sense filter so that the clear lands in the power-on delay.
    cyc(F);
    kick_h(8'h28);
    cyc(40);
    chk(1'h1, ro);
    cyc(T);
    chk(1'h0, ro);
    chk(1'h1, ron);
    chk(1'h1, sw);
    $display("power-up test done");
  endtask
  task t_clr;
    repeat (3) begin
      kick_h(8'h28);
      cyc(T / 2);
      chk(1'h0, ro);
    end
    kick_h(8'h14);
    cyc(T - 40);
    chk(1'h0, ro);
    cyc(80);
    chk(1'h1, ro);
    cyc(T - 80);
    chk(1'h1, ro);
    cyc(80);
    chk(1'h0, ro);
    cyc(T);
    chk(1'h1, ro);
    kick_h(8'h14);
    cyc(30);
    chk(1'h0, ro);
    $display("clear test done");
  endtask
  task t_warn;
    comp.vin_warning = 1'h0;
    comp.vin_startup = 1'h0;
    cyc(F);
    chk(1'h0, sw);
    chk(1'h0, ro);
    comp = 4'hF;
    cyc(F);
    chk(1'h1, sw);
    $display("warning test done");
  endtask
  task t_vrst;
    comp = 4'h8;
    // A dip of the shortest length that must be recognised.
    cyc(VIN_LOW_CYCLES);
    comp = 4'hB;
    chk(1'h1, ro);
    chk(1'h0, sw);
    kick_h(8'h14);
    cyc(30);
    chk(1'h1, ro);
    comp = 4'hF;
    cyc(F);
    kick_h(8'h14);
    cyc(30);
    chk(1'h1, ro);
    cyc(T);
    chk(1'h0, ro);
    $display("sense reset test done");
  endtask
  task t_sup;
    comp.supply_on = 1'h0;
    cyc(D + 10);
    chk(1'h1, ro);
    chk(1'h0, sw);
    cyc(T);
    chk(1'h1, ro);
    comp.supply_on = 1'h1;
    cyc(T + D + 20);
    chk(1'h0, ro);
    $display("supply test done");
  endtask

  // Main sequence.
  initial begin
    cyc(12);
    rst_n = 1'h1;
    t_pwr();
    t_clr();
    t_warn();
    t_vrst();
    t_sup();
    stop_test();
  end
endmodule
`default_nettype wire
